/* File: hw/framer_map.vh */
// Constants for the registration and heartbeat framer.
// Assumes inclusion by framer.v only; definitions only.
`ifndef FRAMER_MAP_VH
`define FRAMER_MAP_VH
// Registration method codes
`define REG_NONE 2'h0
`define REG_MAC 2'h1
`define REG_TAGGED 2'h2
`define REG_CUSTOM 2'h3
// Tagged registration frame and prefix bytes
`define TAG_HDR0 8'hFA
`define TAG_HDR1 8'h07
`define TAG_HDR2 8'h13
`define TAG_HDR3 8'h02
`define TAG_HDR4 8'hFA
`define TAG_HDR5 8'h02
`define TAG_TRL0 8'hFA
`define TAG_TRL1 8'hFF
`define TAG_PFX0 8'hFA
`define TAG_PFX1 8'h01
`define TAG_PFX2 8'h01
`define TAG_HEARTBEAT 8'h00
// Custom string storage, bytes
`define CUSTOM_MAX 33
// Clock rate and keep-alive tick: one second
`define CLK_HZ 250000000
`define TICK_S 1
`define TICK_CYCLES (`CLK_HZ * `TICK_S)
// Hidden probe timeout, in clock cycles; the framer does not use it
`define PROBE_TIMEOUT_CYCLES 16'h0100
`endif

/* File: hw/framer.v */
// Registration and heartbeat framer for the network-side byte stream.
// Assumes a connection manager that reports connect state and send results,
// and a payload source that marks block ends with s_last.
//
// How it works
// - On connect, registration bytes go out before any payload.
// - MAC-on-connect method sends the six MAC bytes when connected.
// - Tagged method sends header, six address bytes, then trailer.
// - Tagged address bytes run from MAC byte five down to zero.
// - Tagged mode puts the three-byte prefix before every payload block.
// - Tagged mode sends one zero heartbeat byte each keep-alive expiry.
// - Custom method sends the stored bytes exactly as configured.
// - Custom storage holds at most thirty-three bytes.
// - Custom strings are sent in datagram mode too.
// - Heartbeats repeat with the keep-alive period.
// - Client reconnects when a heartbeat send fails.
// - Client with an empty heartbeat and a nonzero period runs a hidden probe and reconnects on failure.
`timescale 1ns/1ps
`include "framer_map.vh"
module framer #(
   parameter integer TICK_CYCLES = `TICK_CYCLES,
   parameter integer CUSTOM_MAX = `CUSTOM_MAX
) (
   // Clock and reset
   input wire clk,
   input wire rstn,
   input wire ce,
   // Configuration
   input wire [1:0] reg_method,
   input wire tagged_mode,
   input wire client_mode,
   input wire udp_mode,
   input wire [47:0] mac_addr,
   input wire [15:0] keepalive_s,
   // Custom string storage write port
   input wire cfg_we,
   input wire [5:0] cfg_addr,
   input wire [7:0] cfg_data,
   input wire [5:0] reg_len,
   input wire [5:0] hb_len,
   // Connection manager
   input wire link_up,
   input wire send_fail,
   output reg reconnect,
   output reg probe_req,
   // Payload in
   input wire s_valid,
   input wire [7:0] s_data,
   input wire s_last,
   output wire s_ready,
   // Network byte stream out
   output reg m_valid,
   output reg [7:0] m_data,
   output reg m_last,
   input wire m_ready
);
   // Sequencer states
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_REG = 3'd1;
   localparam [2:0] ST_GAP = 3'd2;
   localparam [2:0] ST_PFX = 3'd3;
   localparam [2:0] ST_DATA = 3'd4;
   localparam [2:0] ST_HB = 3'd5;

   // Custom registration and heartbeat bytes; no reset, so a reconnect keeps them
   reg [7:0] store [0:CUSTOM_MAX-1];

   // Sequencer state and byte index within the current registration, prefix or heartbeat
   reg [2:0] state_q;
   reg [5:0] idx_q;

   // Keep-alive timing: cycles within a tick, ticks within a period
   reg [31:0] tick_q;
   reg [15:0] sec_q;
   reg hb_due_q;
   reg was_up_q;

   // Stream helpers and byte selectors
   wire out_free;
   reg [5:0] reg_total;
   wire [5:0] hb_total;
   reg [7:0] reg_byte;
   reg [7:0] hb_byte;
   reg [7:0] pfx_byte;
   wire hb_enabled;

   // The held byte blocks the next one until the peer takes it, so a stall never drops data
   assign out_free = ~m_valid | m_ready;

   // Bytes of the registration for each method
   always @* begin
      case (reg_method)
         `REG_MAC: reg_total = 6'd6;
         `REG_TAGGED: reg_total = 6'd14;
         `REG_CUSTOM: reg_total = reg_len;
         default: reg_total = 6'd0;
      endcase
   end

   // Tagged heartbeat is one byte; otherwise the configured custom length
   assign hb_total = tagged_mode ? 6'd1 : hb_len;
   // A zero period or empty heartbeat disables heartbeats; a client with an empty heartbeat and a nonzero period falls back to the probe
   assign hb_enabled = (hb_total != 6'd0) && (keepalive_s != 16'h0000);
   // Payload is refused unless a block is being forwarded and the output slot is free
   assign s_ready = ce && (state_q == ST_DATA) && out_free;

   // Custom bytes live in one store: registration first, heartbeat after it
   // Writes past the last byte are dropped rather than wrapping onto byte zero
   always @(posedge clk) begin
      if (ce && cfg_we && (cfg_addr < CUSTOM_MAX)) begin
         store[cfg_addr] <= cfg_data;
      end
   end

   always @* begin
      reg_byte = 8'h00;
      case (reg_method)
         `REG_MAC: reg_byte = mac_addr[8*(5-idx_q) +: 8];
         `REG_TAGGED: begin
            case (idx_q)
               6'd0: reg_byte = `TAG_HDR0;
               6'd1: reg_byte = `TAG_HDR1;
               6'd2: reg_byte = `TAG_HDR2;
               6'd3: reg_byte = `TAG_HDR3;
               6'd4: reg_byte = `TAG_HDR4;
               6'd5: reg_byte = `TAG_HDR5;
               6'd12: reg_byte = `TAG_TRL0;
               6'd13: reg_byte = `TAG_TRL1;
               default: reg_byte = mac_addr[8*(11-idx_q) +: 8];
            endcase
         end
         `REG_CUSTOM: reg_byte = store[idx_q];
         default: reg_byte = 8'h00;
      endcase
   end

   // Custom heartbeat bytes sit right after the registration bytes in the store
   always @* begin
      hb_byte = tagged_mode ? `TAG_HEARTBEAT : store[reg_len + idx_q];
   end

   // Prefix byte for the current index of the three-byte prefix
   always @* begin
      case (idx_q)
         6'd0: pfx_byte = `TAG_PFX0;
         6'd1: pfx_byte = `TAG_PFX1;
         default: pfx_byte = `TAG_PFX2;
      endcase
   end

   // Keep-alive timer: one-second ticks counted against the set period
   // It runs only while connected, so a fresh link always waits a full period first
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_q <= 32'h0000_0000;
         sec_q <= 16'h0000;
         hb_due_q <= 1'b0;
      end else if (ce) begin
         // Disconnected or disabled: hold the timer at zero and forget any due heartbeat
         if (!link_up || keepalive_s == 16'h0000) begin
            tick_q <= 32'h0000_0000;
            sec_q <= 16'h0000;
            hb_due_q <= 1'b0;
         end else begin
            if (tick_q == TICK_CYCLES - 1) begin
               tick_q <= 32'h0000_0000;
               if (sec_q == keepalive_s - 16'h0001) begin
                  sec_q <= 16'h0000;
                  hb_due_q <= 1'b1;
               end else begin
                  sec_q <= sec_q + 16'h0001;
               end
            end else begin
               tick_q <= tick_q + 32'h0000_0001;
            end
            // A new expiry in the clearing cycle is kept
            if (state_q == ST_GAP && hb_due_q && !(tick_q == TICK_CYCLES - 1 && sec_q == keepalive_s - 16'h0001)) begin
               hb_due_q <= 1'b0;
            end
         end
      end
   end

   // Reconnect and hidden probe towards the connection manager
   // A failed probe comes back as send_fail, so one path covers both reconnect cases
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reconnect <= 1'b0;
         probe_req <= 1'b0;
      end else if (ce) begin
         reconnect <= client_mode && link_up && send_fail;
         probe_req <= client_mode && link_up && !hb_enabled && (state_q == ST_GAP) && hb_due_q;
      end
   end

   // Sequencer: registration, then blocks with optional prefix, heartbeats between blocks
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         idx_q <= 6'd0;
         was_up_q <= 1'b0;
         m_valid <= 1'b0;
         m_data <= 8'h00;
         m_last <= 1'b0;
      end else if (ce) begin
         was_up_q <= link_up;
         // The accepted byte leaves; a state below may load the next in the same cycle
         if (m_valid && m_ready) begin
            m_valid <= 1'b0;
            m_last <= 1'b0;
         end
         // A dropped link aborts the sequence in progress but keeps a held byte valid, then waits for the next rise
         if (!link_up) begin
            state_q <= ST_IDLE;
            idx_q <= 6'd0;
         end else begin
            case (state_q)
               // A rising link starts the registration, or goes straight to the gap when none is set
               ST_IDLE: begin
                  if (!was_up_q) begin
                     idx_q <= 6'd0;
                     // Datagram mode uses the same path, so custom strings go out there too
                     state_q <= (reg_total != 6'd0) ? ST_REG : ST_GAP;
                  end
               end

               // One registration byte per free output slot; m_last marks the final one
               ST_REG: begin
                  if (out_free) begin
                     m_valid <= 1'b1;
                     m_data <= reg_byte;
                     m_last <= (idx_q == reg_total - 6'd1);
                     if (idx_q == reg_total - 6'd1) begin
                        idx_q <= 6'd0;
                        state_q <= ST_GAP;
                     end else begin
                        idx_q <= idx_q + 6'd1;
                     end
                  end
               end

               // Gap cycle: the only place a block may start or a heartbeat may go in
               ST_GAP: begin
                  // Block boundary: heartbeat takes priority over new payload
                  idx_q <= 6'd0;
                  if (hb_due_q && hb_enabled) begin
                     state_q <= ST_HB;
                  end else if (s_valid) begin
                     state_q <= tagged_mode ? ST_PFX : ST_DATA;
                  end
               end

               // Fixed prefix ahead of the block in tagged mode
               ST_PFX: begin
                  if (out_free) begin
                     m_valid <= 1'b1;
                     m_data <= pfx_byte;
                     m_last <= 1'b0;
                     if (idx_q == 6'd2) begin
                        idx_q <= 6'd0;
                        state_q <= ST_DATA;
                     end else begin
                        idx_q <= idx_q + 6'd1;
                     end
                  end
               end

               // Payload passes straight through; the byte with s_last ends the block
               ST_DATA: begin
                  if (out_free && s_valid) begin
                     m_valid <= 1'b1;
                     m_data <= s_data;
                     m_last <= s_last;
                     if (s_last) begin
                        state_q <= ST_GAP;
                     end
                  end
               end

               // Heartbeat bytes; a tagged heartbeat is the single zero byte
               ST_HB: begin
                  if (out_free) begin
                     m_valid <= 1'b1;
                     m_data <= hb_byte;
                     m_last <= (idx_q == hb_total - 6'd1);
                     if (idx_q == hb_total - 6'd1) begin
                        idx_q <= 6'd0;
                        state_q <= ST_GAP;
                     end else begin
                        idx_q <= idx_q + 6'd1;
                     end
                  end
               end

               // Unused codes fall back to idle
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // framer

/* File: sim/framer_checker.sv */
// Port-level assertions for the framer.
// Assumes ce is held high by the bench.
`timescale 1ns/1ps
module framer_checker (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Configuration and link
   input wire [1:0] reg_method,
   input wire client_mode,
   input wire link_up,
   input wire send_fail,
   input wire reconnect,
   input wire probe_req,
   // Streams
   input wire s_ready,
   input wire m_valid,
   input wire [7:0] m_data,
   input wire m_last,
   input wire m_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_hold; m_valid && !m_ready |=> m_valid && $stable(m_data) && $stable(m_last); endproperty
   a_hold: assert property (p_hold) else $error("byte moved in stall");
   property p_rec; client_mode && link_up && send_fail |=> reconnect; endproperty
   a_rec: assert property (p_rec) else $error("no reconnect");
   property p_rec_cause; reconnect |-> $past(send_fail) && $past(client_mode); endproperty
   a_rec_cause: assert property (p_rec_cause) else $error("stray reconnect");
   property p_down; (!link_up) [*2] |-> !s_ready; endproperty
   a_down: assert property (p_down) else $error("payload taken while down");
   property p_first; $rose(link_up) && reg_method != 2'h0 |-> !s_ready ##1 !s_ready; endproperty
   a_first: assert property (p_first) else $error("payload before registration");
   property p_mac; $rose(link_up) && reg_method == 2'h1 |-> ##[1:3] m_valid; endproperty
   a_mac: assert property (p_mac) else $error("no address on connect");
   property p_tag; $rose(link_up) && reg_method == 2'h2 |-> ##[1:3] (m_valid && m_data == 8'hFA); endproperty
   a_tag: assert property (p_tag) else $error("frame header missing");
   property p_probe; probe_req |-> $past(client_mode) && $past(link_up); endproperty
   a_probe: assert property (p_probe) else $error("stray probe");
   c_rec: cover property (reconnect);
   c_probe: cover property (probe_req);
   c_last: cover property (m_valid && m_ready && m_last);
endmodule // framer_checker

bind framer framer_checker u_chk (.clk, .rstn, .reg_method, .client_mode, .link_up, .send_fail,
   .reconnect, .probe_req, .s_ready, .m_valid, .m_data, .m_last, .m_ready);

/* File: sim/net_peer.sv */
// Server-side model: takes the outgoing byte stream with random stalls.
// Assumes the bench watches accepted bytes itself.
`timescale 1ns/1ps
module net_peer (
   // Clock and reset
   input wire clk,
   input wire rstn,
   // Stream handshake
   output reg m_ready
);
   integer seed = 32'h79cb_d6b0;
   // Bytes are dropped on arrival, heartbeats included, never used as payload
   always @(negedge clk or negedge rstn) begin
      if (!rstn) m_ready <= 1'b0;
      else m_ready <= ($random(seed) & 3) != 0;
   end
endmodule // net_peer

/* File: sim/tb_top.sv */
// Self-checking bench: stimulus at the falling edge, expected bytes in a queue.
// Assumes net_peer stalls the stream and framer_checker is bound to the design.
`timescale 1ns/1ps
module tb_top;
   reg clk = 1'b0, rstn = 1'b0, tagged_mode = 1'b0, client_mode = 1'b0, udp_mode = 1'b0;
   reg link_up = 1'b0, send_fail = 1'b0, cfg_we = 1'b0, s_valid = 1'b0, s_last = 1'b0;
   reg [1:0] reg_method = 2'h0;
   reg [47:0] mac_addr = 48'h0;
   reg [15:0] keepalive_s = 16'h0;
   reg [5:0] cfg_addr = 6'h0, reg_len = 6'h0, hb_len = 6'h0;
   reg [7:0] cfg_data = 8'h0, s_data = 8'h0;
   wire reconnect, probe_req, s_ready, m_valid, m_last, m_ready;
   wire [7:0] m_data;
   logic [8:0] q[$], hq[$];
   integer seed = 32'h79cb_d6b0;
   integer mismatches = 0, check_count = 0, i, n, probe_cnt = 0;
   always #2 clk = ~clk;
   // Short tick keeps the keep-alive period at ten cycles
   framer #(.TICK_CYCLES(10)) u_dut (.clk, .rstn, .ce(1'b1), .reg_method, .tagged_mode, .client_mode,
      .udp_mode, .mac_addr, .keepalive_s, .cfg_we, .cfg_addr, .cfg_data, .reg_len, .hb_len, .link_up,
      .send_fail, .reconnect, .probe_req, .s_valid, .s_data, .s_last, .s_ready, .m_valid, .m_data, .m_last,
      .m_ready);
   net_peer u_peer (.clk, .rstn, .m_ready);
   task chk(input logic [8:0] exp, input logic [8:0] got);
      begin
         check_count++;
         if (got !== exp) begin
            mismatches++;
            $display("unexpected byte at %0t: expected %h got %h", $time, exp, got);
         end
      end
   endtask
   task chk_flag(input logic exp, input logic got);
      begin
         check_count++;
         if (got !== exp) begin
            mismatches++;
            $display("unexpected flag at %0t: expected %h got %h", $time, exp, got);
         end
      end
   endtask
   task chk_cnt(input logic [31:0] exp, input logic [31:0] got);
      begin
         check_count++;
         if (got !== exp) begin
            mismatches++;
            $display("unexpected count at %0t: expected %h got %h", $time, exp, got);
         end
      end
   endtask
   always @(posedge clk) begin
      if (rstn && probe_req) probe_cnt++;
   end
   // Queue entries carry m_last above the byte; an empty queue expects x, so any extra byte is a mismatch
   always @(posedge clk) begin
      if (rstn && m_valid && m_ready) chk(q.size() ? q.pop_front() : 9'hxxx, {m_last, m_data});
   end
   task drain;
      begin
         for (i = 0; i < 500 && q.size() > 0; i++) @(negedge clk);
         if (q.size() > 0) mismatches++;
      end
   endtask
   task blk(input integer len, input logic pfx);
      integer j, k;
      begin
         if (pfx) q = {q, 9'h0FA, 9'h001, 9'h001};
         for (j = 0; j < len; j++) begin
            s_valid = 1'b1;
            s_data = 8'($random(seed));
            s_last = (j == len - 1);
            q.push_back({s_last, s_data});
            @(posedge clk);
            for (k = 0; k < 200 && !s_ready; k++) @(posedge clk);
            if (k == 200) mismatches++;
            @(negedge clk);
         end
         s_valid = 1'b0;
         @(negedge clk);
      end
   endtask
   task pulse_fail;
      begin
         send_fail = 1'b1;
         @(negedge clk);
         chk_flag(1'b1, reconnect);
         send_fail = 1'b0;
         link_up = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      mac_addr = 48'({$random(seed), $random(seed)});
      reg_method = 2'h2;
      tagged_mode = 1'b1;
      client_mode = 1'b1;
      q = {9'h0FA, 9'h007, 9'h013, 9'h002, 9'h0FA, 9'h002};
      for (i = 5; i >= 0; i--) q.push_back({1'b0, mac_addr[8*i +: 8]});
      q = {q, 9'h0FA, 9'h1FF};
      link_up = 1'b1;
      drain;
      blk(3, 1'b1);
      blk(1, 1'b1);
      drain;
      keepalive_s = 16'h0001;
      q = {9'h100, 9'h100};
      drain;
      keepalive_s = 16'h0000;
      pulse_fail;
      reg_method = 2'h1;
      tagged_mode = 1'b0;
      for (i = 5; i >= 0; i--) q.push_back({i == 0, mac_addr[8*i +: 8]});
      link_up = 1'b1;
      drain;
      blk(2, 1'b0);
      drain;
      pulse_fail;
      reg_method = 2'h3;
      udp_mode = 1'b1;
      // Registration plus two heartbeat bytes stays below the store size
      n = 1 + {$random(seed)} % 30;
      cfg_we = 1'b1;
      for (i = 0; i < n + 2; i++) begin
         cfg_addr = i[5:0];
         cfg_data = 8'($random(seed));
         if (i < n) q.push_back({i == n - 1, cfg_data});
         else hq.push_back({i == n + 1, cfg_data});
         @(negedge clk);
      end
      cfg_we = 1'b0;
      reg_len = n[5:0];
      hb_len = 6'h02;
      link_up = 1'b1;
      drain;
      keepalive_s = 16'h0001;
      q = hq;
      drain;
      keepalive_s = 16'h0000;
      pulse_fail;
      reg_method = 2'h0;
      hb_len = 6'h00;
      keepalive_s = 16'h0001;
      link_up = 1'b1;
      n = probe_cnt;
      repeat (30) @(negedge clk);
      chk_cnt(32'd2, probe_cnt - n);
      pulse_fail;
      test_done;
   end
   initial begin
      #100000;
      mismatches++;
      test_done;
   end
endmodule // tb_top
